/* nibble_alu_flags_datamem.sv */
// ALU, accumulator, condition flags, data memory, timer words and port latches
// Behaviour
// - A 12-bit table address counter supplies the ROM address for table reads.
// - The table counter lives in data memory as nibbles, read and written normally.
// - Two 12-bit timers live in RAM; the second at F8, F9, FA.
// - Unused timer words may hold stack levels 13 and 14 downward.
// - The small variant drops the top RAM address bit, aliasing 80-FF to 00-7F.
// - The ALU makes a 4-bit result, a carry and a zero detect.
// - The 4-bit accumulator is an operand source and takes the result.
// - Subtraction adds the two's complement; carry one means no borrow.
// - Zero detect is one when the ALU output or loaded data is zero.
// - Flags are carry, zero, status, user; pushed on interrupt, restored on return.
// - Carry feeds add and subtract with carry; rotates load the shifted-out bit.
// - Zero flag captures zero detect only for instructions that update it.
// - Status reads one, cleared by instruction conditions, held through next instruction.
// - Branch happens only when status is one.
// - Status forced to one at reset and after the interrupt push.
// - User flag is set, cleared and tested by instructions only.
// - Ports use a separate 5-bit address space, 0 to 31.
// - Output ports are latched; input ports are sampled directly.
// - Port transfers come from the input/output instruction group by port address.
// - The status input port carries the serial port status, not the flag.
// - Stack pointer word decrements after each save, increments before each restore.
`timescale 1ns/1ps
`default_nettype none
module nibble_alu_flags_datamem
   import nibble_core_pkg::*;
#(
   parameter bit SMALL_VARIANT = 1'b0
)
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire op_t i_op,
   input wire logic [7:0] i_addr,
   input wire logic [3:0] i_wdata,
   input wire logic [4:0] i_port_addr,
   input wire logic [PORT_COUNT-1:0][3:0] i_port_in,
   input wire logic i_serial_status,
   input wire logic [7:0] i_rom_data,
   input wire logic [11:0] i_pc,
   input wire logic [1:0] i_timer_tick,
   output logic [3:0] o_acc,
   output logic [3:0] o_flags,
   output logic [11:0] o_rom_addr,
   output logic o_branch,
   output logic [11:0] o_return_pc,
   output logic [PORT_COUNT-1:0][3:0] o_port_latch
);
   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [3:0] acc;
      logic [3:0] flags;
      logic [RAM_WORDS-1:0][3:0] ram;
      logic [PORT_COUNT-1:0][3:0] latch;
      logic [11:0] rom_addr;
      logic branch;
      logic [11:0] return_pc;
   } state_t;

   state_t s;
   state_t next_s;
   logic [PORT_COUNT-1:0][3:0] port_view;
   logic [1:0][11:0] timer_inc;
   logic [3:0] opnd;

   // Physical word for a program address
   function automatic logic [7:0] phys(input logic [7:0] a);
      phys = SMALL_VARIANT ? (a & SMALL_RAM_MASK) : a;
   endfunction

   assign opnd = s.ram[phys(i_addr)];

   // Status input port shows the serial status in place of pin data
   always_comb
   begin
      port_view = i_port_in;
      port_view[STATUS_INPUT_PORT] = {3'h0, i_serial_status};
   end

   // ************************************************************
   // Timer words count in place; stack levels 13/14 may reuse them
   // ************************************************************
   for (genvar t = 0; t < 2; t++)
   begin : g_timer
      localparam logic [7:0] BASE = (t == 0) ? TIMER1_LOW_NIBBLE : TIMER2_LOW_NIBBLE;
      assign timer_inc[t] = {s.ram[phys(BASE + 8'h02)], s.ram[phys(BASE + 8'h01)],
                             s.ram[phys(BASE)]} + 12'h001;
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      logic [4:0] sum;
      logic [3:0] res;
      logic [7:0] base;
      logic [7:0] stack_pointer_word;
      logic [11:0] dc;
      sum = 5'h00;
      res = 4'h0;
      stack_pointer_word = {4'h0, s.ram[phys(STACK_POINTER_WORD)]};
      base = 8'h00;
      dc = {s.ram[phys(TABLE_COUNTER_LOW + 8'h02)], s.ram[phys(TABLE_COUNTER_LOW + 8'h01)],
            s.ram[phys(TABLE_COUNTER_LOW)]};
      next_s = s;
      next_s.branch = 1'b0;
      // Timers first so an instruction write in the same cycle takes priority
      for (int t = 0; t < 2; t++)
      begin
         if (i_timer_tick[t])
         begin
            base = (t == 0) ? TIMER1_LOW_NIBBLE : TIMER2_LOW_NIBBLE;
            next_s.ram[phys(base)] = timer_inc[t][3:0];
            next_s.ram[phys(base + 8'h01)] = timer_inc[t][7:4];
            next_s.ram[phys(base + 8'h02)] = timer_inc[t][11:8];
         end
      end
      // Most instructions leave status at one
      if (i_op != OP_NOP)
      begin
         next_s.flags[STATUS_POS] = 1'b1;
      end
      unique case (i_op)
         OP_NOP:
         begin
         end
         OP_LOAD_RAM:
         begin
            next_s.acc = opnd;
            next_s.flags[ZERO_POS] = (opnd == 4'h0);
         end
         OP_STORE_RAM:
         begin
            next_s.ram[phys(i_addr)] = s.acc;
         end
         OP_ADD, OP_ADD_WITH_CARRY:
         begin
            sum = {1'b0, s.acc} + {1'b0, opnd}
                  + {4'h0, (i_op == OP_ADD_WITH_CARRY) & s.flags[CARRY_POS]};
            next_s.acc = sum[3:0];
            next_s.flags[CARRY_POS] = sum[4];
            next_s.flags[ZERO_POS] = (sum[3:0] == 4'h0);
            next_s.flags[STATUS_POS] = ~sum[4];
         end
         OP_SUBTRACT_WITH_CARRY:
         begin
            // Operand minus accumulator as operand plus inverted accumulator plus no-borrow
            sum = {1'b0, opnd} + {1'b0, ~s.acc} + {4'h0, s.flags[CARRY_POS]};
            next_s.acc = sum[3:0];
            next_s.flags[CARRY_POS] = sum[4];
            next_s.flags[ZERO_POS] = (sum[3:0] == 4'h0);
            next_s.flags[STATUS_POS] = sum[4];
         end
         OP_AND, OP_OR, OP_XOR:
         begin
            if (i_op == OP_AND)
            begin
               res = s.acc & opnd;
            end
            else if (i_op == OP_OR)
            begin
               res = s.acc | opnd;
            end
            else
            begin
               res = s.acc ^ opnd;
            end
            next_s.acc = res;
            next_s.flags[ZERO_POS] = (res == 4'h0);
            next_s.flags[STATUS_POS] = (res != 4'h0);
         end
         OP_ROTATE_LEFT:
         begin
            next_s.acc = {s.acc[2:0], s.flags[CARRY_POS]};
            next_s.flags[CARRY_POS] = s.acc[3];
         end
         OP_ROTATE_RIGHT:
         begin
            next_s.acc = {s.flags[CARRY_POS], s.acc[3:1]};
            next_s.flags[CARRY_POS] = s.acc[0];
         end
         OP_SET_USER:
         begin
            next_s.flags[USER_POS] = 1'b1;
         end
         OP_CLEAR_USER:
         begin
            next_s.flags[USER_POS] = 1'b0;
         end
         OP_TEST_USER:
         begin
            next_s.flags[STATUS_POS] = s.flags[USER_POS];
         end
         OP_TABLE_ADDRESS:
         begin
            next_s.rom_addr = dc;
         end
         OP_TABLE_LOW:
         begin
            next_s.acc = i_rom_data[3:0];
            next_s.flags[ZERO_POS] = (i_rom_data[3:0] == 4'h0);
         end
         OP_TABLE_HIGH_INC:
         begin
            next_s.acc = i_rom_data[7:4];
            next_s.flags[ZERO_POS] = (i_rom_data[7:4] == 4'h0);
            dc = dc + 12'h001;
            next_s.ram[phys(TABLE_COUNTER_LOW)] = dc[3:0];
            next_s.ram[phys(TABLE_COUNTER_LOW + 8'h01)] = dc[7:4];
            next_s.ram[phys(TABLE_COUNTER_LOW + 8'h02)] = dc[11:8];
         end
         OP_PORT_IN:
         begin
            // Pins read unlatched; stability is the outside circuit's job
            next_s.acc = port_view[i_port_addr];
         end
         OP_PORT_OUT:
         begin
            next_s.latch[i_port_addr] = i_wdata;
         end
         OP_INT_ACCEPT:
         begin
            base = STACK_BASE | {2'b00, stack_pointer_word[3:0], 2'b00};
            next_s.ram[phys(base)] = i_pc[3:0];
            next_s.ram[phys(base + 8'h01)] = i_pc[7:4];
            next_s.ram[phys(base + 8'h02)] = i_pc[11:8];
            next_s.ram[phys(base + 8'h03)] = s.flags;
            next_s.ram[phys(STACK_POINTER_WORD)] = stack_pointer_word[3:0] - 4'h1;
            next_s.flags[STATUS_POS] = 1'b1;
         end
         OP_INT_RETURN:
         begin
            stack_pointer_word = stack_pointer_word + 8'h01;
            base = STACK_BASE | {2'b00, stack_pointer_word[3:0], 2'b00};
            next_s.ram[phys(STACK_POINTER_WORD)] = stack_pointer_word[3:0];
            next_s.return_pc = {s.ram[phys(base + 8'h02)], s.ram[phys(base + 8'h01)],
                                s.ram[phys(base)]};
            next_s.flags = s.ram[phys(base + 8'h03)];
         end
         OP_BRANCH:
         begin
            next_s.branch = s.flags[STATUS_POS];
         end
         default:
         begin
         end
      endcase
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         s <= '0;
         s.acc <= ACC_RESET;
         s.flags <= FLAGS_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign o_acc = s.acc;
   assign o_flags = s.flags;
   assign o_rom_addr = s.rom_addr;
   assign o_branch = s.branch;
   assign o_return_pc = s.return_pc;
   assign o_port_latch = s.latch;

   // ************************************************************
   // Checks
   // ************************************************************
   logic [3:0] spw_now;
   assign spw_now = s.ram[phys(STACK_POINTER_WORD)];
   logic [11:0] dc_now;
   assign dc_now = {s.ram[phys(TABLE_COUNTER_LOW + 8'h02)], s.ram[phys(TABLE_COUNTER_LOW + 8'h01)],
                    s.ram[phys(TABLE_COUNTER_LOW)]};

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);

   chk_add_sum_carry: assert property ((i_op == OP_ADD && i_timer_tick == 2'b00) |=>
      ({o_flags[CARRY_POS], o_acc} == $past({1'b0, o_acc}) + $past({1'b0, opnd})))
      else $error("add result or carry wrong");
   chk_sub_no_borrow: assert property ((i_op == OP_SUBTRACT_WITH_CARRY) |=>
      (o_flags[CARRY_POS] == ($past({1'b0, opnd}) >=
      $past({1'b0, o_acc}) + {4'h0, !$past(o_flags[CARRY_POS])})))
      else $error("subtract carry is not no-borrow");
   chk_zero_detect: assert property ((i_op inside {OP_ADD, OP_AND, OP_OR, OP_XOR, OP_LOAD_RAM}) |=>
      (o_flags[ZERO_POS] == (o_acc == 4'h0)))
      else $error("zero flag disagrees with accumulator");
   chk_status_after_push: assert property ((i_op == OP_INT_ACCEPT) |=>
      (o_flags[STATUS_POS] && spw_now == $past(spw_now) - 4'h1))
      else $error("interrupt push did not set status or move pointer");
   chk_branch_on_status: assert property ((i_op == OP_BRANCH) |=>
      (o_branch == $past(o_flags[STATUS_POS])))
      else $error("branch ignored status");
   chk_port_latch_hold: assert property ((i_op != OP_PORT_OUT) |=> $stable(o_port_latch))
      else $error("port latch changed without a write");
   chk_port_latch_write: assert property ((i_op == OP_PORT_OUT) |=>
      (o_port_latch[$past(i_port_addr)] == $past(i_wdata)))
      else $error("port latch missed a write");
   chk_push_pop_flags: assert property ((i_op == OP_INT_ACCEPT && i_timer_tick == 2'b00) ##1
      (i_op == OP_INT_RETURN && i_timer_tick == 2'b00) |=>
      (o_flags == $past(o_flags, 2) && o_return_pc == $past(i_pc, 2)))
      else $error("return did not restore flags and pc");
   chk_user_set: assert property ((i_op == OP_SET_USER) |=> o_flags[USER_POS])
      else $error("user flag not set");
   chk_rotate_carry: assert property ((i_op == OP_ROTATE_LEFT) |=>
      (o_flags[CARRY_POS] == $past(o_acc[3]) && o_acc[0] == $past(o_flags[CARRY_POS])))
      else $error("rotate carry wrong");
   chk_reset_state: assert property (disable iff (1'b0) !i_rstn |=>
      (o_flags == FLAGS_RESET && o_acc == ACC_RESET && !o_branch))
      else $error("reset did not restore flags and accumulator");
   chk_zero_hold: assert property ((i_op inside {OP_NOP, OP_STORE_RAM, OP_ROTATE_LEFT, OP_PORT_IN,
      OP_ROTATE_RIGHT, OP_PORT_OUT, OP_SET_USER, OP_CLEAR_USER, OP_TEST_USER, OP_BRANCH}) |=> $stable(o_flags[ZERO_POS]))
      else $error("zero flag changed by an op that keeps it");
   chk_status_default: assert property ((i_op inside {OP_LOAD_RAM, OP_STORE_RAM, OP_PORT_IN,
      OP_PORT_OUT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_SET_USER, OP_CLEAR_USER, OP_BRANCH, OP_TABLE_LOW,
      OP_TABLE_HIGH_INC}) |=> o_flags[STATUS_POS])
      else $error("status did not return to one");
   chk_flags_hold_idle: assert property ((i_op == OP_NOP) |=> $stable(o_flags))
      else $error("flags changed while idle");
   chk_pop_pointer: assert property ((i_op == OP_INT_RETURN) |=>
      (spw_now == $past(spw_now) + 4'h1))
      else $error("return did not advance the stack pointer word");
   chk_table_step: assert property ((i_op == OP_TABLE_HIGH_INC) |=>
      (dc_now == $past(dc_now) + 12'h001))
      else $error("table counter did not advance");
   chk_push_frame: assert property ((i_op == OP_INT_ACCEPT) |=>
      (s.ram[phys(STACK_BASE | {2'b00, $past(spw_now), 2'b00})] == $past(i_pc[3:0])))
      else $error("interrupt frame not at the stack level");
endmodule
`default_nettype wire

/* nibble_core_pkg.sv */
// Shared constants and types of the nibble ALU, flag and data memory block
package nibble_core_pkg;
   // ************************************************************
   // Data memory map
   // ************************************************************
   localparam logic [7:0] TIMER2_LOW_NIBBLE = 8'hF8;
   localparam logic [7:0] TIMER2_MID_NIBBLE = 8'hF9;
   localparam logic [7:0] TIMER2_HIGH_NIBBLE = 8'hFA;
   localparam logic [7:0] TIMER1_LOW_NIBBLE = 8'hF4;
   localparam logic [7:0] TABLE_COUNTER_LOW = 8'hFC;
   localparam logic [7:0] STACK_POINTER_WORD = 8'hFF;
   // Level n frame at C0 + 4n, so levels 13 and 14 overlay the timer words
   localparam logic [7:0] STACK_BASE = 8'hC0;
   localparam logic [7:0] SMALL_RAM_MASK = 8'h7F;
   localparam int RAM_WORDS = 256;
   localparam int PORT_COUNT = 32;
   // ************************************************************
   // Port address map
   // ************************************************************
   localparam logic [4:0] STATUS_INPUT_PORT = 5'h0E;
   // ************************************************************
   // Flag register layout and reset values
   // ************************************************************
   localparam int CARRY_POS = 3;
   localparam int ZERO_POS = 2;
   localparam int STATUS_POS = 1;
   localparam int USER_POS = 0;
   localparam logic [3:0] FLAGS_RESET = 4'h2;
   localparam logic [3:0] ACC_RESET = 4'h0;
   // ************************************************************
   // Operations presented by the sequencer, one per cycle
   // ************************************************************
   typedef enum logic [4:0] {
      OP_NOP,
      OP_LOAD_RAM,
      OP_STORE_RAM,
      OP_ADD,
      OP_ADD_WITH_CARRY,
      OP_SUBTRACT_WITH_CARRY,
      OP_AND,
      OP_OR,
      OP_XOR,
      OP_ROTATE_LEFT,
      OP_ROTATE_RIGHT,
      OP_SET_USER,
      OP_CLEAR_USER,
      OP_TEST_USER,
      OP_TABLE_ADDRESS,
      OP_TABLE_LOW,
      OP_TABLE_HIGH_INC,
      OP_PORT_IN,
      OP_PORT_OUT,
      OP_INT_ACCEPT,
      OP_INT_RETURN,
      OP_BRANCH
   } op_t;
endpackage

/* ext_port_model.sv */
// Model of the circuitry outside the ports and of the table ROM
`timescale 1ns/1ps
`default_nettype none
module ext_port_model
(
   input wire logic i_clk,
   input wire logic i_set,
   input wire logic [4:0] i_sel,
   input wire logic [3:0] i_val,
   input wire logic i_status,
   input wire logic [11:0] i_rom_addr,
   output logic [31:0][3:0] o_port_in,
   output logic o_serial_status,
   output logic [7:0] o_rom_data
);
   initial
   begin
      o_port_in = '0;
      o_serial_status = 1'b0;
   end
   // Pins move only when told, so data stays put until read
   always @(posedge i_clk)
   begin
      if (i_set)
      begin
         o_port_in[i_sel] <= i_val;
         o_serial_status <= i_status;
      end
   end
   // Pattern from the low address byte, so a wrong table address in bits 7:0 shows
   assign o_rom_data = i_rom_addr[7:0] ^ 8'hC3;
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench of the nibble ALU, flags and data memory
`timescale 1ns/1ps
`default_nettype none
module testbench
   import nibble_core_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   op_t i_op = OP_NOP;
   logic [7:0] i_addr = 8'h00;
   logic [3:0] i_wdata = 4'h0;
   logic [4:0] i_port_addr = 5'h00;
   logic [1:0] i_timer_tick = 2'b00;
   logic [11:0] i_pc = 12'h000;
   logic p_set = 1'b0;
   logic [4:0] p_sel = 5'h00;
   logic [3:0] p_val = 4'h0;
   logic p_status = 1'b0;
   logic [PORT_COUNT-1:0][3:0] port_in;
   logic serial_status;
   logic [7:0] rom_data;
   logic [3:0] o_acc;
   logic [3:0] o_flags;
   logic [11:0] o_rom_addr;
   logic o_branch;
   logic [11:0] o_return_pc;
   logic [PORT_COUNT-1:0][3:0] o_port_latch;
   int err_total = 0;
   int n_compared = 0;
   int i;
   logic [31:0] lfsr = 32'hBC189A91;
   logic ec;
   logic rot;
   logic [3:0] lat [PORT_COUNT];
   logic [6:0] e;
   logic [3:0] a, m, f0;
   logic [7:0] ad;
   op_t op;
   op_t ops [8] = '{OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_CARRY, OP_AND, OP_OR, OP_XOR,
      OP_ROTATE_LEFT, OP_ROTATE_RIGHT};
   always #20 i_clk = ~i_clk;
   // Small variant chosen so that the address aliasing is exercised
   nibble_alu_flags_datamem #(.SMALL_VARIANT(1'b1)) u_nibble_alu_flags_datamem (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_op(i_op), .i_addr(i_addr), .i_wdata(i_wdata), .i_port_addr(i_port_addr), .i_port_in(port_in),
      .i_serial_status(serial_status), .i_rom_data(rom_data), .i_pc(i_pc), .i_timer_tick(i_timer_tick),
      .o_acc(o_acc), .o_flags(o_flags), .o_rom_addr(o_rom_addr), .o_branch(o_branch),
      .o_return_pc(o_return_pc), .o_port_latch(o_port_latch));
   ext_port_model u_ext_port_model (.i_clk(i_clk), .i_set(p_set), .i_sel(p_sel), .i_val(p_val),
      .i_status(p_status), .i_rom_addr(o_rom_addr), .o_port_in(port_in), .o_serial_status(serial_status),
      .o_rom_data(rom_data));
   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected {carry, zero, status, result}
   function automatic logic [6:0] alu(input op_t o, input logic [3:0] x, input logic [3:0] y, input logic c);
      logic [4:0] s;
      logic st;
      case (o)
         OP_ADD: s = x + y;
         OP_ADD_WITH_CARRY: s = x + y + c;
         OP_SUBTRACT_WITH_CARRY: s = {1'b0, y} + {1'b0, ~x} + c;
         OP_AND: s = {c, x & y};
         OP_OR: s = {c, x | y};
         OP_XOR: s = {c, x ^ y};
         OP_ROTATE_LEFT: s = {x, c};
         OP_ROTATE_RIGHT: s = {x[0], c, x[3:1]};
         default: s = {c, x};
      endcase
      case (o)
         OP_ADD, OP_ADD_WITH_CARRY: st = ~s[4];
         OP_SUBTRACT_WITH_CARRY: st = s[4];
         OP_AND, OP_OR, OP_XOR: st = |s[3:0];
         default: st = 1'b1;
      endcase
      return {s[4], s[3:0] == 4'h0, st, s[3:0]};
   endfunction
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic step(input op_t o, input logic [7:0] ad_i);
      i_op = o;
      i_addr = ad_i;
      @(posedge i_clk);
      #1;
      i_op = OP_NOP;
      p_set = 1'b0;
      i_timer_tick = 2'b00;
   endtask
   task automatic pin(input logic [4:0] sel, input logic [3:0] v);
      p_sel = sel;
      p_val = v;
      p_set = 1'b1;
      step(OP_NOP, 8'h00);
   endtask
   task automatic load_acc(input logic [3:0] v);
      pin(5'h03, v);
      i_port_addr = 5'h03;
      step(OP_PORT_IN, 8'h00);
   endtask
   task automatic store(input logic [7:0] ad_i, input logic [3:0] v);
      load_acc(v);
      step(OP_STORE_RAM, ad_i);
   endtask
   task automatic ram_is(input logic [7:0] ad_i, input logic [3:0] v);
      step(OP_LOAD_RAM, ad_i);
      check("ram word", o_acc, v);
   endtask
   task automatic done_test(input string name);
      $display("test %s finished, mismatches so far %0d", name, err_total);
   endtask
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #1000000;
      err_total++;
      give_verdict();
   end
   // ************************************************************
   // Scenarios
   // ************************************************************
   initial
   begin
      repeat (6) @(posedge i_clk);
      #1;
      i_rstn = 1'b1;
      check("reset state", {o_acc, o_flags, o_branch}, 9'h004);
      ec = 1'b0;
      done_test("reset");
      load_acc(4'h9);
      pin(5'h03, 4'h6);
      check("unlatched input", o_acc, 4'h9);
      step(OP_PORT_IN, 8'h00);
      check("reread input", o_acc, 4'h6);
      pin(5'h0E, 4'hF);
      i_port_addr = 5'h0E;
      for (i = 1; i >= 0; i--)
      begin
         p_status = i[0];
         pin(5'h0E, 4'hF);
         step(OP_PORT_IN, 8'h00);
         check("serial status", o_acc, {3'b000, i[0]});
      end
      for (i = 0; i < PORT_COUNT; i++)
      begin
         lfsr = nxt(lfsr);
         lat[i] = lfsr[3:0];
         i_port_addr = i[4:0];
         i_wdata = lat[i];
         step(OP_PORT_OUT, 8'h00);
      end
      for (i = 0; i < PORT_COUNT; i++)
         check("port latch", o_port_latch[i], lat[i]);
      done_test("ports");
      for (i = 0; i < 40; i++)
      begin
         lfsr = nxt(lfsr);
         ad = {lfsr[7], 1'b0, lfsr[13:8]};
         m = lfsr[19:16];
         a = lfsr[23:20];
         op = ops[i % 8];
         if (i < 2)
         begin
            a = 4'hF;
            m = 4'h1;
         end
         rot = (op == OP_ROTATE_LEFT) || (op == OP_ROTATE_RIGHT);
         store(ad, m);
         load_acc(a);
         e = alu(op, a, m, ec);
         step(op, ad ^ 8'h80);
         check("alu result", o_acc, e[3:0]);
         check("alu flags", {o_flags[3], o_flags[2] | rot, o_flags[1]}, {e[6], e[5] | rot, e[4]});
         ec = e[6];
      end
      done_test("alu");
      store(8'h20, 4'h1);
      load_acc(4'h7);
      e = alu(OP_SUBTRACT_WITH_CARRY, 4'h7, 4'h1, ec);
      ec = e[6];
      step(OP_SUBTRACT_WITH_CARRY, 8'h20);
      step(OP_BRANCH, 8'h00);
      check("branch after borrow", o_branch, 1'b0);
      step(OP_BRANCH, 8'h00);
      check("branch plain", o_branch, 1'b1);
      step(OP_NOP, 8'h00);
      check("branch pulse", o_branch, 1'b0);
      step(OP_SET_USER, 8'h00);
      step(OP_TEST_USER, 8'h00);
      check("user set", o_flags[1:0], 2'b11);
      step(OP_CLEAR_USER, 8'h00);
      step(OP_TEST_USER, 8'h00);
      check("user clear", o_flags[1:0], 2'b00);
      done_test("branch and user");
      store(8'hFF, 4'h5);
      step(OP_SET_USER, 8'h00);
      load_acc(4'h7);
      e = alu(OP_SUBTRACT_WITH_CARRY, 4'h7, 4'h1, ec);
      f0 = {e[6:4], 1'b1};
      step(OP_SUBTRACT_WITH_CARRY, 8'h20);
      i_pc = 12'hA5C;
      step(OP_INT_ACCEPT, 8'h00);
      check("flags after accept", o_flags, f0 | 4'h2);
      ram_is(8'hFF, 4'h4);
      for (i = 0; i < 4; i++)
         ram_is(STACK_BASE + 8'h14 + i[7:0], 4'({f0, 12'hA5C} >> (4 * i)));
      step(OP_CLEAR_USER, 8'h00);
      step(OP_INT_RETURN, 8'h00);
      check("restored flags", o_flags, f0);
      check("return pc", o_return_pc, 12'hA5C);
      ram_is(8'hFF, 4'h5);
      // Back to back; flags 4'h3 left by the load just before
      lfsr = nxt(lfsr);
      i_pc = lfsr[11:0];
      step(OP_INT_ACCEPT, 8'h00);
      step(OP_INT_RETURN, 8'h00);
      check("back-to-back pc", o_return_pc, lfsr[11:0]);
      check("back-to-back flags", o_flags, 4'h3);
      ram_is(8'hFF, 4'h5);
      done_test("interrupt");
      store(8'hF8, 4'hF);
      step(OP_STORE_RAM, 8'hF9);
      store(8'hFA, 4'h0);
      i_timer_tick = 2'b11;
      step(OP_NOP, 8'h00);
      ram_is(8'hF8, 4'h0);
      check("zero on load", o_flags[2], 1'b1);
      ram_is(8'hF9, 4'h0);
      ram_is(8'hFA, 4'h1);
      ram_is(8'hF4, 4'h1);
      done_test("timer");
      store(8'hFC, 4'hF);
      step(OP_STORE_RAM, 8'hFD);
      store(8'hFE, 4'h1);
      step(OP_TABLE_ADDRESS, 8'h00);
      check("table address", o_rom_addr, 12'h1FF);
      step(OP_TABLE_LOW, 8'h00);
      check("table low", o_acc, 4'hC);
      step(OP_TABLE_HIGH_INC, 8'h00);
      check("table high", o_acc, 4'h3);
      ram_is(8'hFC, 4'h0);
      ram_is(8'hFD, 4'h0);
      ram_is(8'hFE, 4'h2);
      done_test("table");
      give_verdict();
   end
endmodule
`default_nettype wire
